// ---- common/idf_regs.svh ----
// Register map, reset values and timing constants of the isolated DIO block
`ifndef IDF_REGS_SVH
`define IDF_REGS_SVH

`define IDF_NCH          16
`define IDF_AW           8
// Byte offsets on the Avalon-MM slave
`define IDF_OFS_DIN      8'h00
`define IDF_OFS_DOUT     8'h04
`define IDF_OFS_FILT     8'h08
`define IDF_OFS_MASK     8'h0C
`define IDF_OFS_EDGE     8'h10
`define IDF_OFS_STAT     8'h14
`define IDF_OFS_ICLR     8'h18
`define IDF_OFS_IEN      8'h1C
// Reset values
`define IDF_RST_DOUT     16'h0000
`define IDF_RST_FILT     5'h00
`define IDF_RST_MASK     16'h0000
`define IDF_RST_EDGE     16'h0000
`define IDF_RST_STAT     16'h0000
`define IDF_RST_IEN      16'hFFFF
// Filter setting range and counter width
`define IDF_FILT_MAX     5'h14
`define IDF_FCNT_W       21
// Clock rates in MHz; the sample tick is a fractional divider
`define IDF_CLK_MHZ      5'h19
`define IDF_SMP_MHZ      5'h08

`endif

// ---- common/idf_pkg.sv ----
// Types shared by the isolated DIO block
package idf_pkg;
  typedef enum logic [1:0] {
    IDF_IDLE = 2'b01,
    IDF_ACK  = 2'b10
  } idf_bus_st_t;
endpackage

// ---- src/idf_top.sv ----
// Isolated DIO core: input filter, relay outputs, edge interrupts, Avalon
//
// Contract
// RULE_01 - Input bit reads 1 while its channel is energised, 0 otherwise.
// RULE_02 - Writing 1 to an output bit turns its relay on, 0 off.
// RULE_03 - Reset clears every output bit to 0.
// RULE_04 - Outputs read back without disturbing the driven state.
// RULE_05 - One filter-time setting serves all input channels together.
// RULE_06 - Filtered level changes only after raw level held the filter time.
// RULE_07 - Filter setting spans 0 to 20; zero bypasses the filter.
// RULE_08 - Nonzero setting n gives 2^n periods of an 8 MHz sample clock.
// RULE_09 - Reset clears the filter setting to 0, filter off.
// RULE_10 - Software never writes a filter setting above 20.
// RULE_11 - Each input can interrupt on a change of its filtered level.
// RULE_12 - A masked channel neither sets status nor raises a request.
// RULE_13 - Reset leaves every interrupt mask bit disabled.
// RULE_14 - Edge bit 0 picks rising edges, 1 picks falling edges.
// RULE_15 - Reset clears all edge-select bits to 0.
// RULE_16 - Reading status clears the reported status bits and the request.
// RULE_17 - Reset clears all interrupt status bits to 0.
// RULE_18 - Request stays high while status set; edges during read survive. The code raises it only for status bits whose IEN bit is set.
`timescale 1ns/1ns
`include "idf_regs.svh"

module idf_top
  import idf_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic [`IDF_NCH-1:0]   din,
  output logic      [`IDF_NCH-1:0]   dout,
  output logic                       irq,
  input  wire logic [`IDF_AW-1:0]    avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest
);

  // ************************************************************
  // Declarations
  // ************************************************************
  localparam int NCH = `IDF_NCH;
  localparam int FW  = `IDF_FCNT_W;

  idf_bus_st_t      st_q;
  logic             wait_q;
  logic [31:0]      rdata_q;
  logic [NCH-1:0]   dout_q;
  logic [4:0]       filt_n_q;
  logic [NCH-1:0]   mask_q;
  logic [NCH-1:0]   edge_q;
  logic [NCH-1:0]   stat_q;
  logic [NCH-1:0]   stat_d;
  logic [NCH-1:0]   ien_q;
  logic             irq_q;
  logic [NCH-1:0]   s1_q;
  logic [NCH-1:0]   s2_q;
  logic [NCH-1:0]   s3_q;
  logic [NCH-1:0]   stab_q;
  logic [NCH-1:0]   smp_q;
  logic [NCH-1:0]   filt_q;
  logic [NCH-1:0]   filt_c;
  logic [NCH-1:0]   prev_q;
  logic [NCH-1:0]   hit;
  logic [NCH-1:0]   ev;
  logic [4:0]       acc_q;
  logic [5:0]       acc_nx;
  logic             tick;
  logic [FW-1:0]    limit;
  logic             req;
  logic             ack;
  logic [31:0]      bemask;
  logic [31:0]      rd_mux;
  logic [NCH-1:0]   rd_clr;

  assign req    = avs_read | avs_write;
  assign ack    = req & (st_q == IDF_ACK);
  assign bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // ************************************************************
  // Avalon-MM slave handshake
  // ************************************************************
  // One wait cycle per access: data is prepared, then waitrequest drops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q   <= IDF_IDLE;
      wait_q <= 1'b1;
    end else begin
      case (st_q)
        IDF_IDLE: begin
          if (req) begin
            st_q   <= IDF_ACK;
            wait_q <= 1'b0;
          end
        end
        IDF_ACK: begin
          st_q   <= IDF_IDLE;
          wait_q <= 1'b1;
        end
        default: begin
          st_q   <= IDF_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address & 8'hFC)
      `IDF_OFS_DIN:  rd_mux[NCH-1:0] = filt_c;  // RULE_01
      `IDF_OFS_DOUT: rd_mux[NCH-1:0] = dout_q;  // RULE_04
      `IDF_OFS_FILT: rd_mux[4:0]     = filt_n_q;
      `IDF_OFS_MASK: rd_mux[NCH-1:0] = mask_q;
      `IDF_OFS_EDGE: rd_mux[NCH-1:0] = edge_q;
      `IDF_OFS_STAT: rd_mux[NCH-1:0] = stat_q;
      `IDF_OFS_IEN:  rd_mux[NCH-1:0] = ien_q;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is sampled while waitrequest is still high
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (req && st_q == IDF_IDLE && avs_read) begin
      rdata_q <= rd_mux;
    end
  end

  // ************************************************************
  // Software-written registers
  // ************************************************************
  // Writes take effect only at the edge where waitrequest is low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dout_q <= `IDF_RST_DOUT;  // RULE_03
    end else if (ack && avs_write &&
                 (avs_address & 8'hFC) == `IDF_OFS_DOUT) begin
      dout_q <= (dout_q & ~bemask[NCH-1:0]) |
                (avs_writedata[NCH-1:0] & bemask[NCH-1:0]);  // RULE_02
    end
  end

  // Settings beyond 20 are the host's fault and are stored as written
  always_ff @(posedge clk) begin
    if (!nrst) begin
      filt_n_q <= `IDF_RST_FILT;  // RULE_09
    end else if (ack && avs_write && avs_byteenable[0] &&
                 (avs_address & 8'hFC) == `IDF_OFS_FILT) begin
      filt_n_q <= avs_writedata[4:0];  // RULE_05
    end
  end

  // Mask bit 1 enables the channel
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mask_q <= `IDF_RST_MASK;  // RULE_13
      edge_q <= `IDF_RST_EDGE;  // RULE_15
      ien_q  <= `IDF_RST_IEN;
    end else if (ack && avs_write) begin
      if ((avs_address & 8'hFC) == `IDF_OFS_MASK) begin
        mask_q <= (mask_q & ~bemask[NCH-1:0]) |
                  (avs_writedata[NCH-1:0] & bemask[NCH-1:0]);
      end
      if ((avs_address & 8'hFC) == `IDF_OFS_EDGE) begin
        edge_q <= (edge_q & ~bemask[NCH-1:0]) |
                  (avs_writedata[NCH-1:0] & bemask[NCH-1:0]);
      end
      if ((avs_address & 8'hFC) == `IDF_OFS_IEN) begin
        ien_q <= (ien_q & ~bemask[NCH-1:0]) |
                 (avs_writedata[NCH-1:0] & bemask[NCH-1:0]);
      end
    end
  end

  // ************************************************************
  // Input synchroniser and sample tick
  // ************************************************************
  // Stable level follows only when the second and third stages agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      stab_q <= '0;
    end else begin
      s1_q   <= din;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      stab_q <= (s2_q == s3_q) ? s3_q : stab_q;  // RULE_01
    end
  end

  // Sum kept one bit wider; at five bits it would wrap when 24 + 8 reaches 32
  assign acc_nx = {1'b0, acc_q} + {1'b0, `IDF_SMP_MHZ};
  assign tick   = (acc_nx >= {1'b0, `IDF_CLK_MHZ});  // RULE_08

  // Fractional divider: 8 ticks in every 25 clocks, 8 MHz on average
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_q <= 5'h00;
    end else if (tick) begin
      acc_q <= 5'(acc_nx - {1'b0, `IDF_CLK_MHZ});
    end else begin
      acc_q <= acc_nx[4:0];
    end
  end
  // One shared length for every channel; 2^n sample periods
  assign limit = FW'(1) << filt_n_q;  // RULE_05 RULE_08

  // ************************************************************
  // Per-channel digital filter and edge detection
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      logic [FW-1:0] cnt_q;
      // Counter runs only while the sample differs from the filtered level
      assign hit[gi] = tick && smp_q[gi] == stab_q[gi] &&
                       smp_q[gi] != filt_q[gi] && cnt_q == limit - FW'(1);
      always_ff @(posedge clk) begin
        if (!nrst) begin
          cnt_q       <= '0;
          smp_q[gi]   <= 1'b0;
          filt_q[gi]  <= 1'b0;
        end else if (filt_n_q == 5'd0) begin
          cnt_q       <= '0;
          smp_q[gi]   <= stab_q[gi];
          filt_q[gi]  <= stab_q[gi];
        end else if (tick) begin
          smp_q[gi] <= stab_q[gi];
          if (stab_q[gi] != smp_q[gi] || smp_q[gi] == filt_q[gi]) begin
            cnt_q <= '0;  // RULE_06
          end else if (hit[gi]) begin
            cnt_q      <= '0;
            filt_q[gi] <= smp_q[gi];  // RULE_06
          end else begin
            cnt_q <= cnt_q + FW'(1);
          end
        end
      end
      // Bypass passes the synchronised level straight through
      assign filt_c[gi] = (filt_n_q == 5'd0) ? stab_q[gi]
                                              : filt_q[gi];  // RULE_07
      // Edge select: 0 rising, 1 falling; masked channels never fire
      assign ev[gi] = mask_q[gi] &  // RULE_12
                      (edge_q[gi] ? (prev_q[gi] & ~filt_c[gi])
                                  : (~prev_q[gi] & filt_c[gi]));  // RULE_14
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_q <= '0;
    end else begin
      prev_q <= filt_c;  // RULE_11
    end
  end

  // ************************************************************
  // Interrupt status and request
  // ************************************************************
  // Only bits already returned to software are cleared by the read
  assign rd_clr = (ack && avs_read &&
                   (avs_address & 8'hFC) == `IDF_OFS_STAT)
                  ? rdata_q[NCH-1:0] : '0;

  always_comb begin
    stat_d = stat_q & ~rd_clr;  // RULE_16
    if (ack && avs_write && (avs_address & 8'hFC) == `IDF_OFS_ICLR) begin
      stat_d = stat_d & ~(avs_writedata[NCH-1:0] & bemask[NCH-1:0]);
    end
    stat_d = stat_d | ev;  // RULE_11 RULE_18
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stat_q <= `IDF_RST_STAT;  // RULE_17
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q  <= |(stat_d & ien_q);  // RULE_18
    end
  end

  assign dout            = dout_q;
  assign irq             = irq_q;
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_in_sync;  // RULE_01
    @(posedge clk) disable iff (!nrst)
      (s2_q == s3_q) |=> (stab_q == $past(s3_q));
  endproperty
  a_in_sync: assert property (p_in_sync)  // RULE_01
    else $error("input level lost");

  property p_out_wr;  // RULE_02
    @(posedge clk) disable iff (!nrst)
      (ack && avs_write && avs_byteenable == 4'hF &&
       (avs_address & 8'hFC) == `IDF_OFS_DOUT)
      |=> (dout == $past(avs_writedata[NCH-1:0]));
  endproperty
  a_out_wr: assert property (p_out_wr)  // RULE_02
    else $error("output write missed");

  property p_out_rst;  // RULE_03
    @(posedge clk) !nrst |=> (dout == 16'h0000 && filt_n_q == 5'd0);
  endproperty
  a_out_rst: assert property (p_out_rst)  // RULE_03 RULE_09
    else $error("outputs not cleared");

  property p_out_rd;  // RULE_04
    @(posedge clk) disable iff (!nrst)
      (ack && avs_read) |=> $stable(dout);
  endproperty
  a_out_rd: assert property (p_out_rd)  // RULE_04
    else $error("read changed outputs");

  property p_filt_hold;  // RULE_06
    @(posedge clk) disable iff (!nrst)
      ($past(filt_n_q) != 5'd0 && filt_n_q == $past(filt_n_q) &&
       $changed(filt_q)) |-> ($past(hit) != 16'h0000);
  endproperty
  a_filt_hold: assert property (p_filt_hold)  // RULE_06
    else $error("early filter");

  property p_bypass;  // RULE_07
    @(posedge clk) disable iff (!nrst)
      (filt_n_q == 5'd0 && req && st_q == IDF_IDLE && avs_read &&
       (avs_address & 8'hFC) == `IDF_OFS_DIN)
      |=> (avs_readdata[NCH-1:0] == $past(stab_q));
  endproperty
  a_bypass: assert property (p_bypass)  // RULE_07
    else $error("bypass broken");

  property p_cfg_rst;  // RULE_13
    @(posedge clk) !nrst |=> (mask_q == 16'h0000 && edge_q == 16'h0000
                              && stat_q == 16'h0000);
  endproperty
  a_cfg_rst: assert property (p_cfg_rst)  // RULE_13 RULE_15 RULE_17
    else $error("bad reset config");

  property p_masked;  // RULE_12
    @(posedge clk) disable iff (!nrst)
      ##1 ((stat_q & ~$past(stat_q) & ~$past(mask_q)) == 16'h0000);
  endproperty
  a_masked: assert property (p_masked)  // RULE_12
    else $error("masked bit set");

  property p_rise;  // RULE_14
    @(posedge clk) disable iff (!nrst)
      (mask_q[0] && !edge_q[0] && !prev_q[0] && filt_c[0]) |=> stat_q[0];
  endproperty
  a_rise: assert property (p_rise)  // RULE_14
    else $error("rising edge missed");

  property p_rd_clr;  // RULE_16
    @(posedge clk) disable iff (!nrst)
      (ack && avs_read && (avs_address & 8'hFC) == `IDF_OFS_STAT &&
       ev == 16'h0000) |=> ((stat_q & $past(rdata_q[NCH-1:0])) == 16'h0000);
  endproperty
  a_rd_clr: assert property (p_rd_clr)  // RULE_16
    else $error("status not cleared");

  property p_irq;  // RULE_18
    @(posedge clk) disable iff (!nrst)
      ((stat_q & ien_q) != 16'h0000) |-> ##[0:1] irq;
  endproperty
  a_irq: assert property (p_irq)  // RULE_18
    else $error("request dropped");

endmodule

// ---- dv/idf_host.sv ----
// Host model: Avalon-MM master that reaches the DIO registers
`timescale 1ns/1ns
`include "idf_regs.svh"

module idf_host (
  input  wire logic               clk,
  output logic [`IDF_AW-1:0]      avs_address,
  output logic                    avs_read,
  output logic                    avs_write,
  output logic [31:0]             avs_writedata,
  output logic [3:0]              avs_byteenable,
  input  wire logic [31:0]        avs_readdata,
  input  wire logic               avs_waitrequest
);
  // Idle bus from time zero
  initial begin
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = 4'hF;
  end

  // ********************************************
  // Bus cycles
  // ********************************************
  // Request held until waitrequest is seen low; no cycle count assumed
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    access(1'b0, a, 32'h0000_0000, q);
  endtask

  // Codes past the top setting would leave the filter undefined
  task automatic set_filt(input logic [4:0] n);
    logic [4:0] v;
    v = (n > `IDF_FILT_MAX) ? `IDF_FILT_MAX : n;
    wr(`IDF_OFS_FILT, {27'h000_0000, v});
  endtask
endmodule

// ---- dv/test_isolated_dio_filter_irq.sv ----
// Self-checking bench of the isolated DIO core with a host model
`timescale 1ns/1ns
`include "idf_regs.svh"

module test_isolated_dio_filter_irq;
  logic               clk;
  logic               nrst;
  logic [15:0]        din;
  logic [15:0]        dout;
  logic               irq;
  logic [7:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [3:0]         avs_byteenable;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  int                 n_mismatch;
  int                 compares;
  int                 cyc;

  idf_top idf_top_i (
    .clk(clk), .nrst(nrst), .din(din), .dout(dout), .irq(irq),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  idf_host idf_host_i (
    .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  // 25 MHz clock
  always #20 clk = ~clk;

  // ********************************************
  // Checking helpers
  // ********************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    idf_host_i.rd(a, q);
    chk(q, exp);
  endtask

  task automatic w8(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic results();
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard: whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end

  // ********************************************
  // Scenarios
  // ********************************************
  task automatic t_reset();
    chk({16'h0000, dout}, 32'h0000_0000);
    rchk(`IDF_OFS_DOUT, 32'h0000_0000);
    rchk(`IDF_OFS_FILT, 32'h0000_0000);
    rchk(`IDF_OFS_MASK, 32'h0000_0000);
    rchk(`IDF_OFS_EDGE, 32'h0000_0000);
    rchk(`IDF_OFS_STAT, 32'h0000_0000);
    rchk(`IDF_OFS_IEN, 32'h0000_FFFF);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
  endtask

  // Every relay bit switched both ways; readback leaves outputs alone
  task automatic t_dout();
    logic [15:0] v [2];
    v = '{16'hA5C3, 16'h5A3C};
    foreach (v[i]) begin
      idf_host_i.wr(`IDF_OFS_DOUT, {16'h0000, v[i]});
      w8(1);
      chk({16'h0000, dout}, {16'h0000, v[i]});
      rchk(`IDF_OFS_DOUT, {16'h0000, v[i]});
      chk({16'h0000, dout}, {16'h0000, v[i]});
    end
  endtask

  // Bypass: raw levels show after the synchroniser only
  task automatic t_din();
    logic [15:0] v [2];
    v = '{16'h1234, 16'hEDCB};
    foreach (v[i]) begin
      din <= v[i];
      w8(8);
      rchk(`IDF_OFS_DIN, {16'h0000, v[i]});
    end
  endtask

  // Setting 4 means 16 sample ticks, 2 us or 50 clocks, on all channels
  task automatic t_filt();
    idf_host_i.set_filt(5'h04);
    din <= 16'h1234;
    w8(25);
    din <= 16'hEDCB;
    w8(80);
    rchk(`IDF_OFS_DIN, 32'h0000_EDCB);
    din <= 16'h1234;
    w8(20);
    rchk(`IDF_OFS_DIN, 32'h0000_EDCB);
    w8(60);
    rchk(`IDF_OFS_DIN, 32'h0000_1234);
    idf_host_i.set_filt(5'h14);
    rchk(`IDF_OFS_FILT, 32'h0000_0014);
    idf_host_i.set_filt(5'h00);
  endtask

  // Bit0 rises on rise select, bit1 falls on fall select, bit2 masked
  task automatic t_irq();
    din <= 16'h0002;
    w8(8);
    idf_host_i.wr(`IDF_OFS_EDGE, 32'h0000_0002);
    idf_host_i.wr(`IDF_OFS_MASK, 32'h0000_0003);
    din <= 16'h0005;
    w8(10);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    w8(20);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    rchk(`IDF_OFS_STAT, 32'h0000_0003);
    w8(2);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rchk(`IDF_OFS_STAT, 32'h0000_0000);
    din <= 16'h0000;
    w8(10);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rchk(`IDF_OFS_STAT, 32'h0000_0000);
  endtask

  // Enable gates the line only; clear register drops status
  task automatic t_ien();
    idf_host_i.wr(`IDF_OFS_IEN, 32'h0000_0000);
    din <= 16'h0001;
    w8(10);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    idf_host_i.wr(`IDF_OFS_IEN, 32'h0000_FFFF);
    w8(2);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    idf_host_i.wr(`IDF_OFS_ICLR, 32'h0000_0001);
    w8(2);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rchk(`IDF_OFS_STAT, 32'h0000_0000);
    rchk(`IDF_OFS_ICLR, 32'h0000_0000);
    rchk(8'h20, 32'h0000_0000);
    idf_host_i.wr(`IDF_OFS_DIN, 32'h0000_FFFF);
    rchk(`IDF_OFS_DIN, 32'h0000_0001);
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    din = 16'h0000;
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_dout();
    t_din();
    t_filt();
    t_irq();
    t_ien();
    results();
  end
endmodule
